// >>> e1fg_defs.svh
`ifndef E1FG_DEFS_SVH
`define E1FG_DEFS_SVH
// Overview of operation
// - Four configuration bits pick transparent, basic, CRC, modified CRC or CAS framing.
// - Even frames carry alignment word in TS0 bits 2-8; odd frames bit 2 is one.
// - One-shot inversion of one alignment bit, one alignment word or one NFAS bit.
// - Basic framing: stored international values fill bit 1 unless disabled.
// - A bit sends one on manual alarm or selected automatic alarm criterion.
// - Basic framing: each enabled Sa4-Sa8 sends its first stored value.
// - CRC mode: pattern 001011 in bit 1 of first six odd frames.
// - CRC of each sub-multiframe goes into C bits of the next one.
// - One-shot inversion of all four CRC bits of one sub-multiframe.
// - E bits send zero for a sub-multiframe whose received CRC failed.
// - E bits send stored values when out of sync with reporting enabled, or when reporting is disabled but international insertion is not.
// - CRC mode: enabled Sa bits send four code-word bits in turn.
// - CAS mode: 0000 in TS16 bits 1-4 of frame 0 of every 16.
// - One-shot inversion of one signaling alignment pattern.
// - CAS mode: extra bits fill TS16 bits 5, 7, 8 of frame 0.
// - CAS mode: multiframe alarm value goes into TS16 bit 6 of frame 0.
// - CAS mode: TS16 forced to zeros or ones; zeros win.
// - Modified CRC mode changes only Sa and CRC positions.
// - Framing disabled: payload passes through unchanged.
// - Flags set at first bit of alignment frame, frame, multiframe, SMF, CAS MF.
// - Active-low interrupt while any enabled flag is set.

`define E1FG_ADDR_MODE   8'h62
`define E1FG_ADDR_INTL   8'h63
`define E1FG_ADDR_SACTL  8'h64
`define E1FG_ADDR_CW0    8'h65
`define E1FG_ADDR_CW4    8'h69
`define E1FG_ADDR_EXTRA  8'h6a
`define E1FG_ADDR_MAINT  8'h6b
`define E1FG_ADDR_IRQEN  8'h6d
`define E1FG_ADDR_FLAGS  8'h6e
`define E1FG_ADDR_EINJ   8'h6f
`define E1FG_ADDR_POS    8'h70

`define E1FG_CFG_FRAMING_DISABLE    0
`define E1FG_CFG_CRC_GENERATE_ENABLE  1
`define E1FG_CFG_MCRC    2
`define E1FG_CFG_SIGNALING_MF_ENABLE   3
`define E1FG_CFG_INTL_INSERT_DISABLE   4
`define E1FG_CFG_FAR_END_ERROR_DISABLE 5
`define E1FG_CFG_EXTRA_BITS_DISABLE    6

`define E1FG_EI_ONEFAS   0
`define E1FG_EI_ALLFAS   1
`define E1FG_EI_NFAS     2
`define E1FG_EI_MFAS     3
`define E1FG_EI_CAS      4
`define E1FG_EI_CRC      5

`define E1FG_MT_REMOTE_ALARM_MANUAL   0
`define E1FG_MT_AUTO     1
`define E1FG_MT_CRIT     2
`define E1FG_MT_MULTIFRAME_ALARM_BIT    3
`define E1FG_MT_LOS      4
`define E1FG_MT_AIS      5

`define E1FG_FL_FAS      0
`define E1FG_FL_BF       1
`define E1FG_FL_MF       2
`define E1FG_FL_SMF      3
`define E1FG_FL_SIG      4

`define E1FG_FAS_WORD    7'b0011011
`define E1FG_MFAS_WORD   6'b001011
`define E1FG_SIG_TS      5'h10
`define E1FG_CRC_POLY    4'h3
`define E1FG_RST_BYTE    8'h00
`endif

// >>> e1fg_pkg.sv
`include "e1fg_defs.svh"
package e1fg_pkg;
    typedef logic [7:0] e1fg_addr_t;
    typedef logic [7:0] e1fg_data_t;

    typedef enum logic [3:0] {
        E1FG_TRANS = 4'b0001,
        E1FG_BASIC = 4'b0010,
        E1FG_CRC   = 4'b0100,
        E1FG_MCRC  = 4'b1000
    } e1fg_mode_t;

    typedef struct packed {
        logic [7:0]      cfg;
        logic [1:0]      intl;
        logic [5:0]      einj;
        logic [4:0]      sa_en;
        logic [4:0][3:0] cw;
        logic [2:0]      extra;
        logic [5:0]      maint;
        logic [4:0]      irq_en;
        logic [4:0]      flags;
        logic [7:0]      bit_cnt;
        logic [3:0]      frm_cnt;
        logic [5:0]      act;
        logic [3:0]      crc_hold;
        logic [1:0]      e_pend;
        logic            out_bit;
        logic            out_valid;
        logic [7:0]      rdata;
    } e1fg_state_t;
endpackage : e1fg_pkg

// >>> e1fg_crc4.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1fg_defs.svh"
module e1fg_crc4 (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       bit_en,
    input  wire logic       smf_start,
    input  wire logic       din,
    output logic [3:0]      crc
);
    import e1fg_pkg::*;

    logic [3:0] crc_reg;

    // MSB-first division; feedback at the input gives the remainder of M*x^4
    function automatic logic [3:0] e1fg_crc_step(input logic [3:0] s, input logic d);
        logic fb;
        fb = d ^ s[3];
        return {s[2:0], 1'b0} ^ (fb ? `E1FG_CRC_POLY : 4'h0);
    endfunction : e1fg_crc_step

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= 4'h0;
        end else if (bit_en) begin
            crc_reg <= e1fg_crc_step(smf_start ? 4'h0 : crc_reg, din);
        end
    end

    assign crc = crc_reg;
endmodule : e1fg_crc4
`default_nettype wire

// >>> e1fg_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "e1fg_defs.svh"
module e1fg_top (
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire e1fg_pkg::e1fg_addr_t reg_addr,
    input  wire e1fg_pkg::e1fg_data_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output e1fg_pkg::e1fg_data_t    reg_rdata,
    input  wire logic               tx_in_valid,
    input  wire logic               tx_in_bit,
    output logic                    tx_out_valid,
    output logic                    tx_out_bit,
    input  wire logic               rx_crc_mf_out_of_sync,
    input  wire logic               rx_crc_err,
    input  wire logic               rx_crc_err_smf,
    input  wire logic               rx_rai_cond_a,
    input  wire logic               rx_rai_cond_b,
    output logic                    int_n
);
    import e1fg_pkg::*;

    // Named copies so single pattern bits can be picked by position
    localparam logic [6:0] fas_word  = `E1FG_FAS_WORD;
    localparam logic [5:0] mfas_word = `E1FG_MFAS_WORD;

    e1fg_state_t st;
    e1fg_state_t next_st;
    e1fg_mode_t  mode;
    logic        rst_meta;
    logic        rst_n;
    logic        cas;
    logic        crc_any;
    logic        first;
    logic        even;
    logic [4:0]  ts;
    logic [2:0]  p;
    logic [3:0]  f;
    logic [3:0]  crc_cur;
    logic [3:0]  crcval;
    logic        smf_start;
    logic        o;
    logic        czero;
    logic        rai;
    logic [2:0]  sai;
    logic        ei;
    logic [4:0]  fl_set;
    logic [5:0]  fresh;
    logic [5:0]  bound;
    logic        wr_einj;
    logic        wr_flags;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_comb begin
        if (st.cfg[`E1FG_CFG_FRAMING_DISABLE]) begin
            mode = E1FG_TRANS;
        end else if (st.cfg[`E1FG_CFG_CRC_GENERATE_ENABLE]) begin
            mode = st.cfg[`E1FG_CFG_MCRC] ? E1FG_MCRC : E1FG_CRC;
        end else begin
            mode = E1FG_BASIC;
        end
    end

    // CAS rides on basic or plain CRC framing, never on modified CRC
    assign cas       = st.cfg[`E1FG_CFG_SIGNALING_MF_ENABLE] && (mode == E1FG_BASIC || mode == E1FG_CRC);
    assign crc_any   = (mode == E1FG_CRC) || (mode == E1FG_MCRC);
    assign ts        = st.bit_cnt[7:3];
    assign p         = st.bit_cnt[2:0];
    assign f         = st.frm_cnt;
    assign even      = !f[0];
    assign first     = tx_in_valid && (st.bit_cnt == 8'h00);
    assign smf_start = first && (f[2:0] == 3'h0);
    assign crcval    = smf_start ? crc_cur : st.crc_hold;
    assign rai       = st.maint[`E1FG_MT_REMOTE_ALARM_MANUAL] || (st.maint[`E1FG_MT_AUTO] &&
                       (st.maint[`E1FG_MT_CRIT] ? rx_rai_cond_b : rx_rai_cond_a));
    assign sai       = 3'(p - 3'd3);
    assign ei        = f[1];
    assign wr_einj   = reg_wr && (reg_addr == `E1FG_ADDR_EINJ);
    assign wr_flags  = reg_wr && (reg_addr == `E1FG_ADDR_FLAGS);

    e1fg_crc4 u_crc (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_en    (tx_in_valid && crc_any),
        .smf_start (smf_start),
        .din       (czero ? 1'b0 : o),
        .crc       (crc_cur)
    );

    always_comb begin
        next_st = st;
        o       = tx_in_bit;
        czero   = 1'b0;
        fl_set  = 5'h00;
        fresh   = 6'h00;
        bound   = 6'h00;
        next_st.rdata     = 8'h00;
        next_st.out_valid = tx_in_valid;

        // Inversion requests are armed at the boundary of the unit they spoil
        fresh[`E1FG_EI_ONEFAS] = st.einj[`E1FG_EI_ONEFAS] && even && mode != E1FG_MCRC;
        fresh[`E1FG_EI_ALLFAS] = st.einj[`E1FG_EI_ALLFAS] && even && mode != E1FG_MCRC;
        fresh[`E1FG_EI_NFAS]   = st.einj[`E1FG_EI_NFAS] && !even && mode != E1FG_MCRC;
        fresh[`E1FG_EI_MFAS]   = st.einj[`E1FG_EI_MFAS] && mode == E1FG_CRC && f == 4'h0;
        fresh[`E1FG_EI_CAS]    = st.einj[`E1FG_EI_CAS] && cas && f == 4'h0;
        fresh[`E1FG_EI_CRC]    = st.einj[`E1FG_EI_CRC] && crc_any && f[2:0] == 3'h0;
        bound = {f[2:0] == 3'h0, f == 4'h0, f == 4'h0, 3'b111};
        if (first) begin
            for (int i = 0; i < 6; i++) begin
                if (bound[i]) begin
                    next_st.act[i] = fresh[i] && mode != E1FG_TRANS;
                end
            end
            next_st.einj = st.einj & ~(fresh & {6{mode != E1FG_TRANS}});
        end
        if (smf_start) begin
            next_st.crc_hold = crcval;
        end

        if (tx_in_valid && mode != E1FG_TRANS && ts == 5'h00) begin
            if (even) begin
                if (p == 3'd0) begin
                    if (crc_any) begin
                        o     = crcval[2'd3 - f[2:1]] ^ next_st.act[`E1FG_EI_CRC];
                        czero = 1'b1;
                    end else if (!st.cfg[`E1FG_CFG_INTL_INSERT_DISABLE]) begin
                        o = st.intl[1];
                    end
                end else if (mode != E1FG_MCRC) begin
                    o = fas_word[3'd7 - p] ^ next_st.act[`E1FG_EI_ALLFAS] ^
                        (next_st.act[`E1FG_EI_ONEFAS] && p == 3'd1);
                end
            end else begin
                if (p == 3'd0) begin
                    if (mode == E1FG_CRC && f < 4'd12) begin
                        o = mfas_word[3'd5 - f[3:1]] ^ next_st.act[`E1FG_EI_MFAS];
                    end else if (mode == E1FG_CRC) begin
                        if (!st.cfg[`E1FG_CFG_FAR_END_ERROR_DISABLE] && !rx_crc_mf_out_of_sync) begin
                            o = !st.e_pend[ei];
                            next_st.e_pend[ei] = 1'b0;
                        end else if (!st.cfg[`E1FG_CFG_FAR_END_ERROR_DISABLE] || !st.cfg[`E1FG_CFG_INTL_INSERT_DISABLE]) begin
                            o = ei ? st.intl[0] : st.intl[1];
                        end
                    end else if (mode == E1FG_BASIC && !st.cfg[`E1FG_CFG_INTL_INSERT_DISABLE]) begin
                        o = st.intl[0];
                    end
                end else if (p == 3'd1) begin
                    if (mode != E1FG_MCRC) begin
                        o = 1'b1 ^ next_st.act[`E1FG_EI_NFAS];
                    end
                end else if (p == 3'd2) begin
                    if (mode != E1FG_MCRC) begin
                        o = rai;
                    end
                end else if (st.sa_en[sai]) begin
                    o = crc_any ? st.cw[sai][f[2:1]] : st.cw[sai][0];
                end
            end
        end

        if (tx_in_valid && cas && ts == `E1FG_SIG_TS) begin
            if (f == 4'h0) begin
                if (p < 3'd4) begin
                    o = next_st.act[`E1FG_EI_CAS];
                end else if (p == 3'd5) begin
                    o = st.maint[`E1FG_MT_MULTIFRAME_ALARM_BIT];
                end else if (!st.cfg[`E1FG_CFG_EXTRA_BITS_DISABLE]) begin
                    o = (p == 3'd4) ? st.extra[0] :
                        (p == 3'd6) ? st.extra[1] : st.extra[2];
                end
            end
            if (st.maint[`E1FG_MT_LOS]) begin
                o = 1'b0;
            end else if (st.maint[`E1FG_MT_AIS]) begin
                o = 1'b1;
            end
        end

        if (tx_in_valid) begin
            next_st.out_bit = o;
            next_st.bit_cnt = 8'(st.bit_cnt + 8'd1);
            if (st.bit_cnt == 8'hff) begin
                next_st.frm_cnt = 4'(st.frm_cnt + 4'd1);
            end
        end

        if (first && mode != E1FG_TRANS) begin
            fl_set[`E1FG_FL_FAS] = even;
            fl_set[`E1FG_FL_BF]  = 1'b1;
            fl_set[`E1FG_FL_MF]  = crc_any && f == 4'h0;
            fl_set[`E1FG_FL_SMF] = crc_any && f[2:0] == 3'h0;
            fl_set[`E1FG_FL_SIG] = cas && f == 4'h0;
        end
        // A boundary that lands on the clearing write is not lost
        next_st.flags = (st.flags & ~(wr_flags ? reg_wdata[4:0] : 5'h00)) | fl_set;
        if (rx_crc_err) begin
            next_st.e_pend[rx_crc_err_smf] = 1'b1;
        end

        if (reg_wr) begin
            unique case (reg_addr)
                `E1FG_ADDR_MODE:  next_st.cfg    = reg_wdata;
                `E1FG_ADDR_INTL:  next_st.intl   = reg_wdata[1:0];
                `E1FG_ADDR_SACTL: next_st.sa_en  = reg_wdata[4:0];
                `E1FG_ADDR_EXTRA: next_st.extra  = reg_wdata[2:0];
                `E1FG_ADDR_MAINT: next_st.maint  = reg_wdata[5:0];
                `E1FG_ADDR_IRQEN: next_st.irq_en = reg_wdata[4:0];
                `E1FG_ADDR_EINJ:  next_st.einj   = next_st.einj | reg_wdata[5:0];
                default: begin
                    if (reg_addr >= `E1FG_ADDR_CW0 && reg_addr <= `E1FG_ADDR_CW4) begin
                        next_st.cw[3'(reg_addr - `E1FG_ADDR_CW0)] = reg_wdata[3:0];
                    end
                end
            endcase
        end

        if (reg_rd) begin
            unique case (reg_addr)
                `E1FG_ADDR_MODE:  next_st.rdata = st.cfg;
                `E1FG_ADDR_INTL:  next_st.rdata = {6'h00, st.intl};
                `E1FG_ADDR_SACTL: next_st.rdata = {3'h0, st.sa_en};
                `E1FG_ADDR_EXTRA: next_st.rdata = {5'h00, st.extra};
                `E1FG_ADDR_MAINT: next_st.rdata = {2'h0, st.maint};
                `E1FG_ADDR_IRQEN: next_st.rdata = {3'h0, st.irq_en};
                `E1FG_ADDR_FLAGS: next_st.rdata = {3'h0, st.flags};
                `E1FG_ADDR_EINJ:  next_st.rdata = {2'h0, st.einj};
                `E1FG_ADDR_POS:   next_st.rdata = {f, 1'b0, ts[4:2]};
                default: begin
                    if (reg_addr >= `E1FG_ADDR_CW0 && reg_addr <= `E1FG_ADDR_CW4) begin
                        next_st.rdata = {4'h0, st.cw[3'(reg_addr - `E1FG_ADDR_CW0)]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata    = st.rdata;
    assign tx_out_valid = st.out_valid;
    assign tx_out_bit   = st.out_bit;
    assign int_n        = !(|(st.flags & st.irq_en));

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_pass_through: assert property (tx_in_valid && mode == E1FG_TRANS && !reg_wr
        |=> tx_out_valid && tx_out_bit == $past(tx_in_bit))
        else $error("transparent bit altered");
    a_nfas_one: assert property (tx_in_valid && mode == E1FG_BASIC && ts == 5'h00 && !even
        && p == 3'd1 && !st.act[`E1FG_EI_NFAS] |=> tx_out_bit)
        else $error("NFAS bit not one");
    a_fas_fourth_bit: assert property (tx_in_valid && mode == E1FG_BASIC && ts == 5'h00 && even
        && p == 3'd3 && !st.act[`E1FG_EI_ALLFAS] |=> tx_out_bit)
        else $error("FAS bit 4 wrong");
    a_mfas_third: assert property (tx_in_valid && mode == E1FG_CRC && ts == 5'h00
        && f == 4'd5 && p == 3'd0 && !st.act[`E1FG_EI_MFAS] |=> tx_out_bit)
        else $error("MFAS pattern wrong");
    a_sig_zero: assert property (tx_in_valid && cas && ts == `E1FG_SIG_TS
        && st.maint[`E1FG_MT_LOS] |=> !tx_out_bit)
        else $error("TS16 not forced to zero");
    a_flag_frame: assert property (first && mode != E1FG_TRANS
        |=> st.flags[`E1FG_FL_BF])
        else $error("frame flag not set");
    a_irq_frame: assert property (first && mode != E1FG_TRANS
        && st.irq_en[`E1FG_FL_BF] && !reg_wr |=> !int_n)
        else $error("interrupt not raised");
    a_einj_once: assert property (first && even && mode == E1FG_BASIC
        && st.einj[`E1FG_EI_ALLFAS] && !wr_einj |=> !st.einj[`E1FG_EI_ALLFAS])
        else $error("word inversion request not consumed");
    a_e_unchanged: assert property (tx_in_valid && mode == E1FG_CRC && ts == 5'h00
        && f == 4'd13 && p == 3'd0 && st.cfg[`E1FG_CFG_FAR_END_ERROR_DISABLE] && st.cfg[`E1FG_CFG_INTL_INSERT_DISABLE]
        && !cas |=> tx_out_bit == $past(tx_in_bit))
        else $error("E bit changed");

    c_crc_mf: cover property (first && mode == E1FG_CRC && f == 4'h0);
    c_cas_mf: cover property (first && cas && f == 4'h0);
    c_crc_inv: cover property (smf_start && next_st.act[`E1FG_EI_CRC]);
    c_word_inv: cover property (first && even && next_st.act[`E1FG_EI_ALLFAS]);
endmodule : e1fg_top
`default_nettype wire

// >>> e1fg_pl_src.sv
`timescale 1ns/100ps
`default_nettype none
module e1fg_pl_src (
    input  wire logic clk_sys,
    input  wire logic run,
    output logic      bit_valid,
    output logic      bit_data
);
    logic [1:0] dice;
    initial begin
        bit_valid = 1'b0;
        bit_data  = 1'b0;
    end
    // Idle source keeps toggling its data line so a stale bit is never trusted
    always @(posedge clk_sys) begin
        dice = 2'($urandom);
        if (run && dice != 2'h0) begin
            bit_valid <= 1'b1;
            bit_data  <= 1'($urandom);
        end else begin
            bit_valid <= 1'b0;
            bit_data  <= ~bit_data;
        end
    end
endmodule : e1fg_pl_src
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1fg_defs.svh"
module tb_top;
    import e1fg_pkg::*;
    localparam logic [6:0] FAW = `E1FG_FAS_WORD;
    localparam logic [5:0] MFW = `E1FG_MFAS_WORD;
    localparam int         NC  = 12;
    logic       clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    logic       oos = 1'b0, crc_err = 1'b0, err_smf = 1'b0, rai_a = 1'b0, rai_b = 1'b0;
    e1fg_addr_t reg_addr = 8'h00;
    e1fg_data_t reg_wdata = 8'h00, reg_rdata;
    logic       tx_in_valid, tx_in_bit, tx_out_valid, tx_out_bit, int_n;
    int         err_count = 0, checks = 0, f = 0, b = 0, nbit = 0, e_k = 0;
    logic [7:0] m_cfg, m_intl, m_sa, m_ext, m_mt, m_ei, d;
    logic [3:0] m_cw [5];
    logic [3:0] acc, hold;
    logic [5:0] act;
    logic [1:0] e_pend;
    logic       hold_ok, clean, e_v = 1'b0, e_b, e_c;
    logic [7:0] t_cfg [NC] = '{8'h00, 8'h10, 8'h01, 8'h02, 8'h02, 8'h22, 8'h32, 8'h08,
                               8'h48, 8'h0a, 8'h0a, 8'h06};
    logic [7:0] t_mt  [NC] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
                               8'h10, 8'h20, 8'h30, 8'h01};
    logic [7:0] t_ei  [NC] = '{8'h06, 8'h01, 8'h00, 8'h08, 8'h00, 8'h20, 8'h00, 8'h10,
                               8'h00, 8'h00, 8'h00, 8'h00};
    int         t_mf  [NC] = '{1, 1, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1};

    always #20 clk_sys = ~clk_sys;

    e1fg_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_in_valid(tx_in_valid), .tx_in_bit(tx_in_bit), .tx_out_valid(tx_out_valid),
        .tx_out_bit(tx_out_bit), .rx_crc_mf_out_of_sync(oos), .rx_crc_err(crc_err),
        .rx_crc_err_smf(err_smf), .rx_rai_cond_a(rai_a), .rx_rai_cond_b(rai_b),
        .int_n(int_n));
    e1fg_pl_src i_src (.clk_sys(clk_sys), .run(run), .bit_valid(tx_in_valid),
        .bit_data(tx_in_bit));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic chk_bit(input string what);
        check(what, {7'h0, tx_out_bit}, {7'h0, e_b});
    endtask : chk_bit

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        check("reg_read", d, exp);
    endtask : rdchk

    task automatic run_bits(input int n);
        int t;
        t = nbit + n;
        @(posedge clk_sys);
        run <= 1'b1;
        for (int i = 0; i < 3 * n && nbit < t; i++) @(posedge clk_sys);
        run <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : run_bits

    // Reference framer: one call per accepted payload bit
    task automatic step(input logic din);
        logic fas, modified_crc_select, mc, cas, rai, o, fb;
        int   p, q, k;
        fas  = (f % 2 == 0);
        p    = b % 8;
        q    = (f % 8) / 2;
        mc   = m_cfg[1] & m_cfg[2];
        modified_crc_select = m_cfg[1] & ~m_cfg[2];
        cas  = m_cfg[3] & ~mc;
        rai  = m_mt[0] | (m_mt[1] & (m_mt[2] ? rai_b : rai_a));
        if (b == 0 && !m_cfg[0]) begin
            if (fas) {act[1:0], m_ei[1:0]} = {m_ei[1:0], 2'b00};
            else {act[2], m_ei[2]} = {m_ei[2], 1'b0};
            if (f == 0) {act[4:3], m_ei[4:3]} = {m_ei[4:3], 2'b00};
            if (f % 8 == 0) begin
                {act[5], m_ei[5]} = {m_ei[5], 1'b0};
                clean = modified_crc_select | mc;
                acc   = 4'h0;
            end
        end
        o   = din;
        e_k = 0;
        e_c = 1'b1;
        if (!m_cfg[0] && b < 8) begin
            if (p == 0 && (modified_crc_select | mc)) begin
                if (fas) {e_k, e_c, o} = {32'd4, hold_ok, hold[3 - q] ^ act[5]};
                else if (modified_crc_select && f < 12) {e_k, o} = {32'd1, MFW[5 - f / 2] ^ act[3]};
                else if (modified_crc_select) begin
                    e_k = 2;
                    k   = (f == 13) ? 0 : 1;
                    if (!m_cfg[5] && !oos) {o, e_pend[k]} = {~e_pend[k], 1'b0};
                    else if (!m_cfg[5] || !m_cfg[4]) o = m_intl[1 - k];
                end
            end else if (p == 0) begin
                e_k = 2;
                if (!m_cfg[4]) o = m_intl[fas];
            end else if (!mc && fas) {e_k, o} = {32'd1, FAW[7 - p] ^ (act[1] | (act[0] & p == 1))};
            else if (!mc && p < 3) {e_k, o} = (p == 1) ? {32'd1, ~act[2]} : {32'd3, rai};
            if (!fas && p >= 3 && m_sa[p - 3]) {e_k, o} = {32'd3, m_cw[p - 3][(modified_crc_select | mc) ? q : 0]};
        end
        if (!m_cfg[0] && cas && b / 8 == 16) begin
            e_k = 5;
            if (f == 0 && p < 4) o = act[4];
            else if (f == 0 && p == 5) o = m_mt[3];
            else if (f == 0 && !m_cfg[6]) o = m_ext[p == 4 ? 0 : p - 5];
            if (m_mt[4]) o = 1'b0;
            else if (m_mt[5]) o = 1'b1;
        end
        // CRC runs over the sent bits with the check positions taken as zero
        fb  = acc[3] ^ ((e_k == 4) ? 1'b0 : o);
        acc = {acc[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
        if (!(modified_crc_select | mc)) clean = 1'b0;
        if (f % 8 == 7 && b == 255) {hold, hold_ok} = {acc, clean};
        e_b = o;
        b   = (b + 1) % 256;
        if (b == 0) f = (f + 1) % 16;
    endtask : step

    always @(posedge clk_sys) begin
        if (resetn) check("out_valid", {7'h0, tx_out_valid}, {7'h0, e_v});
        if (e_v && e_c) case (e_k)
            0: chk_bit("payload_bit");
            1: chk_bit("align_bit");
            2: chk_bit("intl_or_e_bit");
            3: chk_bit("alarm_or_sa_bit");
            4: chk_bit("crc_bit");
            default: chk_bit("sig_slot_bit");
        endcase
        e_v = 1'b0;
        if (!resetn) begin
            {f, b, act, e_pend, hold_ok, clean, acc, hold} = '0;
            {m_cfg, m_intl, m_sa, m_ext, m_mt, m_ei} = '0;
            m_cw = '{default: 4'h0};
        end else if (tx_in_valid) begin
            step(tx_in_bit);
            e_v = 1'b1;
            nbit++;
        end
        if (resetn && crc_err) e_pend[err_smf] = 1'b1;
        if (resetn && reg_wr) case (reg_addr)
            8'h62: m_cfg = reg_wdata;
            8'h63: m_intl = reg_wdata;
            8'h64: m_sa = reg_wdata;
            8'h65, 8'h66, 8'h67, 8'h68, 8'h69: m_cw[reg_addr - 8'h65] = reg_wdata[3:0];
            8'h6a: m_ext = reg_wdata;
            8'h6b: m_mt = reg_wdata;
            8'h6f: m_ei = m_ei | reg_wdata;
            default: ;
        endcase
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (95000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h0426_3b90));
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(8'h62, 8'h00);
        rdchk(8'h63, 8'h00);
        rdchk(8'h6f, 8'h00);
        wr(8'h40, 8'hff);
        rdchk(8'h40, 8'h00);
        $display("register test done");
        for (int i = 0; i < NC; i++) begin
            wr(8'h62, t_cfg[i]);
            wr(8'h63, 8'($urandom) & 8'h03);
            wr(8'h64, 8'($urandom) & 8'h1f);
            for (int j = 0; j < 5; j++) wr(8'h65 + 8'(j), 8'($urandom) & 8'h0f);
            wr(8'h6a, 8'($urandom) & 8'h07);
            wr(8'h6b, t_mt[i] | (8'($urandom) & 8'h04));
            wr(8'h6f, t_ei[i]);
            rai_a <= 1'($urandom);
            rai_b <= 1'($urandom);
            oos   <= (i == 4);
            if (t_cfg[i][1]) begin
                @(posedge clk_sys);
                crc_err <= 1'b1;
                err_smf <= 1'($urandom);
                @(posedge clk_sys);
                crc_err <= 1'b0;
            end
            run_bits(t_mf[i] * 4096);
            rdchk(8'h6f, 8'h00);
            rdchk(8'h62, t_cfg[i]);
            $display("frame case %0d done", i);
        end
        wr(8'h62, 8'h00);
        wr(8'h6d, 8'h02);
        wr(8'h6e, 8'h1f);
        rdchk(8'h6e, 8'h00);
        run_bits(600);
        rdchk(8'h6e, 8'h03);
        #1 check("irq_line", {7'h0, int_n}, 8'h00);
        wr(8'h6d, 8'h00);
        #1 check("irq_line", {7'h0, int_n}, 8'h01);
        rdchk(8'h70, {4'(f), 1'b0, 3'(b / 32)});
        $display("flag test done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
